// ==== dv/core_model.sv ====
// Purpose: analog core stand-in answering start pulses with a result
// Assumes: one start at a time, fixed latency in clock cycles
// Notes: data bus shows the inverse of its last value outside done
`timescale 1ns/10ps

module core_model
    import conv_seq_pkg::*;
#(
    parameter int LATENCY = 6
)
(
    // clock
    input wire logic i_clock,
    // start request
    input wire logic i_start,
    input wire logic [CHANNEL_WIDTH-1:0] i_channel,
    // answer
    output logic o_done,
    output logic [RESULT_WIDTH-1:0] o_data
);
    int left = 0;
    logic [CHANNEL_WIDTH-1:0] chan = '0;

    initial
    begin
        o_done = 1'b0;
        o_data = 10'h000;
    end

    // stale data toggles so a late sample cannot look right
    always @(posedge i_clock)
    begin
        o_done <= 1'b0;
        o_data <= ~o_data;
        if (i_start)
        begin
            left <= LATENCY;
            chan <= i_channel;
        end
        else if (left == 1)
        begin
            left <= 0;
            o_done <= 1'b1;
            o_data <= {6'h2d, chan};
        end
        else if (left > 1)
        begin
            left <= left - 1;
        end
    end
endmodule // core_model

// ==== dv/tb.sv ====
// Purpose: self-checking bench for the sequencer and transfer unit
// Assumes: software and pin triggers, core answered by core_model
// Notes: expected words are {6'h2d, channel}, zero-extended on the bus
`timescale 1ns/10ps

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    $display("ERROR %s exp %h got %h", nm, e, g); bad_count++; end end

module tb;
    import conv_seq_pkg::*;
    logic i_clock = 1'b0, i_resetn = 1'b0, arm = 1'b0, multi_sample_convert = 1'b0, sw = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [3:0] chsel = 4'h0;
    logic [7:0] cnt = 8'h00;
    logic [15:0] sa = 16'h1000;
    logic saw = 1'b0, two = 1'b0, clr = 1'b0, rdy = 1'b1;
    logic pin = 1'b0, swsel = 1'b1, cont = 1'b0;
    logic start, done, mwr, hold, act, flag, b1, abort;
    logic [3:0] chan;
    logic [9:0] cdata, res;
    logic [15:0] maddr, mdata;
    logic [3:0] chans[$];
    logic [15:0] addrs[$], words[$];
    int bad_count = 0, num_checks = 0, aborts = 0;

    always #50 i_clock = ~i_clock;

    conv_seq conv_seq_inst (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_conversion_sequence_select(mode), .i_input_channel_select(chsel),
        .i_conversion_arm(arm), .i_multi_sample_convert(multi_sample_convert),
        .i_trigger_is_software(swsel), .i_software_start_conversion(sw),
        .i_sample_trigger_input(pin), .i_transfer_count(cnt),
        .i_transfer_start_address(sa), .i_start_address_write(saw),
        .i_two_block_select(two), .i_continuous_transfer(cont),
        .i_completion_flag_clear(clr), .o_core_start(start), .o_core_abort(abort),
        .o_core_channel(chan), .i_core_done(done), .i_core_data(cdata),
        .i_bus_ready(rdy), .o_mem_write(mwr), .o_mem_address(maddr),
        .o_mem_data(mdata), .o_cpu_hold(hold), .o_conversion_result(res),
        .o_converter_active(act), .o_completion_flag(flag), .o_block_one_full(b1));

    core_model core_model_inst (.i_clock(i_clock), .i_start(start), .i_channel(chan),
        .o_done(done), .o_data(cdata));

    // record starts and bus writes mid-cycle, where outputs have settled
    always @(negedge i_clock)
    begin
        if (start) chans.push_back(chan);
        if (abort) aborts++;
        if (mwr) begin addrs.push_back(maddr); words.push_back(mdata); end
        `CHK("cpu_hold", mwr, hold)
    end

    task automatic pulse(ref logic s);
        @(posedge i_clock); #1 s = 1'b1;
        @(posedge i_clock); #1 s = 1'b0;
    endtask

    // one pin rise, then room for synchroniser and one conversion
    task automatic pin_pulse();
        pulse(pin);
        repeat (20) @(posedge i_clock);
        #1;
    endtask

    // software start then wait for the operation to drain
    task automatic run();
        int n;
        pulse(sw);
        n = 0;
        while (act !== 1'b0 && n < 400) begin @(posedge i_clock); #1 n++; end
        `CHK("active_end", 1'b0, act)
        repeat (6) @(posedge i_clock);
        #1;
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic t_single();
        chans = {}; mode = 2'h0; chsel = 4'h5; arm = 1'b1;
        run();
        `CHK("chan", 4'h5, chans[0])
        `CHK("result", {6'h2d, 4'h5}, res)
        `CHK("flag", 1'b1, flag)
        pulse(clr);
        run();
        `CHK("restarts", 2, chans.size())
        `CHK("no_dtc", 0, addrs.size())
        pulse(sw);
        repeat (3) @(posedge i_clock);
        #1 arm = 1'b0;
        repeat (12) @(posedge i_clock);
        #1;
        `CHK("aborts", 1, aborts)
        `CHK("abort_idle", 1'b0, act)
        $display("test single done");
    endtask

    task automatic t_sequence();
        chans = {}; mode = 2'h1; chsel = 4'h3; multi_sample_convert = 1'b1; arm = 1'b1;
        run();
        `CHK("seq_len", 4, chans.size())
        for (int k = 0; k < 4; k++) `CHK("seq_chan", 4'(3 - k), chans[k])
        `CHK("seq_result", {6'h2d, 4'h0}, res)
        $display("test sequence done");
    endtask

    // the bus stalls through the whole sequence, words wait in the queue
    task automatic t_one_block();
        arm = 1'b0; cnt = 8'h04; sa = 16'h1000;
        pulse(saw); pulse(clr);
        addrs = {}; words = {}; rdy = 1'b0; arm = 1'b1;
        run();
        `CHK("stalled", 0, addrs.size())
        `CHK("flag_wait", 1'b0, flag)
        rdy = 1'b1;
        repeat (12) @(posedge i_clock);
        #1;
        for (int k = 0; k < 4; k++)
        begin
            `CHK("addr", 16'h1000 + 16'(2 * k), addrs[k])
            `CHK("data", {6'h0, 6'h2d, 4'(3 - k)}, words[k])
        end
        `CHK("flag_block", 1'b1, flag)
        run();
        `CHK("stopped", 4, addrs.size())
        $display("test one block done");
    endtask

    task automatic t_two_block();
        arm = 1'b0; cnt = 8'h02; two = 1'b1; chsel = 4'h1; cont = 1'b1;
        pulse(saw); pulse(clr);
        addrs = {}; arm = 1'b1;
        run();
        `CHK("b1_set", 1'b1, b1)
        `CHK("flag_b1", 1'b1, flag)
        pulse(clr);
        run();
        for (int k = 0; k < 4; k++) `CHK("addr2", 16'h1000 + 16'(2 * k), addrs[k])
        `CHK("b1_clr", 1'b0, b1)
        `CHK("flag_b2", 1'b1, flag)
        run();
        `CHK("cont_addr", 16'h1000, addrs[4])
        `CHK("cont_b1", 1'b1, b1)
        $display("test two block done");
    endtask

    task automatic t_repeat();
        arm = 1'b0; cnt = 8'h00; two = 1'b0; cont = 1'b0;
        mode = 2'h2; chsel = 4'h7; chans = {}; arm = 1'b1;
        pulse(sw);
        repeat (40) @(posedge i_clock);
        #1 arm = 1'b0;
        run();
        `CHK("repeats", 1'b1, chans.size() >= 3)
        foreach (chans[k]) `CHK("rep_chan", 4'h7, chans[k])
        `CHK("rep_result", {6'h2d, 4'h7}, res)
        $display("test repeat done");
    endtask

    // pin trigger: repeat sequence steps per edge, single needs a rearm
    task automatic t_pin();
        chans = {}; mode = 2'h3; chsel = 4'h1; multi_sample_convert = 1'b0; swsel = 1'b0; arm = 1'b1;
        repeat (2) pin_pulse();
        `CHK("rep_seq_wrap", 4'h1, chan)
        pin_pulse();
        arm = 1'b0;
        pin_pulse();
        `CHK("seq_halt", 1'b0, act)
        pin_pulse();
        mode = 2'h0; arm = 1'b1;
        repeat (2) pin_pulse();
        arm = 1'b0;
        @(posedge i_clock);
        #1 arm = 1'b1;
        pin_pulse();
        `CHK("pin_starts", 6, chans.size())
        for (int k = 0; k < 4; k++) `CHK("pin_chan", 4'(k % 2 == 0), chans[k])
        $display("test pin trigger done");
    endtask

    initial
    begin
        repeat (10) @(posedge i_clock);
        #1 i_resetn = 1'b1;
        t_single();
        t_sequence();
        t_one_block();
        t_two_block();
        t_repeat();
        t_pin();
        end_of_test();
    end

    // whole run is well under 2000 cycles
    initial
    begin
        repeat (5000) @(posedge i_clock);
        bad_count++;
        end_of_test();
    end
endmodule // tb

// ==== rtl/conv_seq.sv ====
// Purpose: conversion sequencer and result transfer unit with result queue
// Assumes: analog core outside; control bits only change while disarmed
// Notes: one clock; sample trigger pin synchronised by two flip-flops
// Functional notes
// - sequence select decodes single, sequence, repeats
// - single mode converts selected channel once
// - software start retriggers; other triggers need rearm
// - sequence descends from selected channel to zero
// - repeat single converts selected channel continuously
// - repeat sequence restarts from selected on trigger
// - multi convert: first edge, then automatic starts
// - multi convert ignores edges until end/rearm
// - disarm in single mode aborts at once
// - disarm in repeat single finishes current conversion
// - disarm in sequence modes finishes the sequence
// - mode zero plus disarm halts immediately
// - transfer unit active when count nonzero
// - each transfer one cycle, processor held off
// - one block spans start to start+2n-2
// - pointer steps by two, counter down one
// - one block stops at zero until address rewrite
// - second block spans start+2n to start+4n-2
// - block fills set flag, toggle block-one-full
// - continuous reloads pointer and counter after last
// - trigger edge starts each conversion unless multi convert
// - flag per result without transfer, else per block
`timescale 1ns/10ps

module result_fifo
#(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
)
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd_ptr;
        logic [AW-1:0] wr_ptr;
        logic [AW:0] fill;
    } fifo_state_type;

    fifo_state_type fifo_ff;
    fifo_state_type nxt_fifo;
    logic push;
    logic pop;

    // honest full and empty straight from the fill count
    assign o_in_ready = (fifo_ff.fill != (AW+1)'(DEPTH));
    assign o_out_valid = (fifo_ff.fill != '0);
    assign o_out_data = fifo_ff.mem[fifo_ff.rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // next fifo state
    always_comb
    begin
        nxt_fifo = fifo_ff;
        if (push)
        begin
            nxt_fifo.mem[fifo_ff.wr_ptr] = i_in_data;
            nxt_fifo.wr_ptr = fifo_ff.wr_ptr + 1'b1;
        end
        if (pop)
        begin
            nxt_fifo.rd_ptr = fifo_ff.rd_ptr + 1'b1;
        end
        nxt_fifo.fill = fifo_ff.fill + (AW+1)'(push) - (AW+1)'(pop);
    end

    // register the fifo state
    always_ff @(posedge i_clock)
    begin
        if (!i_resetn)
        begin
            fifo_ff <= '0;
        end
        else
        begin
            fifo_ff <= nxt_fifo;
        end
    end
endmodule // result_fifo

module conv_seq
    import conv_seq_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // sequencer control
    input wire logic [1:0] i_conversion_sequence_select,
    input wire logic [CHANNEL_WIDTH-1:0] i_input_channel_select,
    input wire logic i_conversion_arm,
    input wire logic i_multi_sample_convert,
    input wire logic i_trigger_is_software,
    input wire logic i_software_start_conversion,
    input wire logic i_sample_trigger_input,
    // transfer unit control
    input wire logic [COUNT_WIDTH-1:0] i_transfer_count,
    input wire logic [ADDRESS_WIDTH-1:0] i_transfer_start_address,
    input wire logic i_start_address_write,
    input wire logic i_two_block_select,
    input wire logic i_continuous_transfer,
    input wire logic i_completion_flag_clear,
    // analog core handshake
    output logic o_core_start,
    output logic o_core_abort,
    output logic [CHANNEL_WIDTH-1:0] o_core_channel,
    input wire logic i_core_done,
    input wire logic [RESULT_WIDTH-1:0] i_core_data,
    // system memory bus
    input wire logic i_bus_ready,
    output logic o_mem_write,
    output logic [ADDRESS_WIDTH-1:0] o_mem_address,
    output logic [WORD_WIDTH-1:0] o_mem_data,
    output logic o_cpu_hold,
    // status
    output logic [RESULT_WIDTH-1:0] o_conversion_result,
    output logic o_converter_active,
    output logic o_completion_flag,
    output logic o_block_one_full
);

    typedef struct packed {
        seq_state_type state;
        logic [CHANNEL_WIDTH-1:0] channel;
        logic rearm_needed;
        logic [1:0] trigger_sync;
        logic trigger_prev;
        logic [RESULT_WIDTH-1:0] result;
        logic core_start;
        logic core_abort;
        logic completion;
        logic block_one_full;
        logic in_block_two;
        logic stopped;
        logic primed;
        logic [ADDRESS_WIDTH-1:0] pointer;
        logic [COUNT_WIDTH-1:0] counter;
        mem_write_type wr;
    } seq_top_state_type;

    // mode decoding shared by the sequencer and checks
    function automatic logic is_sequence(input logic [1:0] mode);
        return (mode == MODE_SEQUENCE) || (mode == MODE_REPEAT_SEQUENCE);
    endfunction

    function automatic logic is_repeat(input logic [1:0] mode);
        return (mode == MODE_REPEAT_SINGLE) || (mode == MODE_REPEAT_SEQUENCE);
    endfunction

    seq_top_state_type st_ff;
    seq_top_state_type nxt_st;
    logic trigger_edge;
    logic result_load;
    logic dtc_enabled;
    logic dtc_running;
    logic can_start;
    logic abort_now;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    result_word_type fifo_in;
    result_word_type fifo_out;
    logic [ADDRESS_WIDTH-1:0] cur_pointer;
    logic [COUNT_WIDTH-1:0] cur_counter;

    // trigger source: software pulse, or synchronised pin rising edge
    assign trigger_edge = i_trigger_is_software ? i_software_start_conversion
        : (st_ff.trigger_sync[1] && !st_ff.trigger_prev);
    assign result_load = (st_ff.state == SEQ_CONVERT) && i_core_done;
    assign dtc_enabled = (i_transfer_count != COUNT_ZERO);
    assign dtc_running = dtc_enabled && !st_ff.stopped;
    // a full queue holds the next sample back rather than lose a word
    assign can_start = !dtc_running || fifo_in_ready;
    // immediate halt: single mode disarm, or mode zero with disarm
    assign abort_now = !i_conversion_arm
        && (i_conversion_sequence_select == MODE_SINGLE)
        && ((st_ff.state == SEQ_CONVERT) || (st_ff.state == SEQ_START));
    assign fifo_in.data = i_core_data;
    // an address write that cycle wins, so the word waits instead of being lost
    assign fifo_pop = fifo_out_valid && i_bus_ready && dtc_running && !i_start_address_write;
    // first transfer after a start address write picks up start and n
    assign cur_pointer = st_ff.primed ? st_ff.pointer : i_transfer_start_address;
    assign cur_counter = st_ff.primed ? st_ff.counter : i_transfer_count;

    result_fifo #(
        .WIDTH(RESULT_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_in_valid(result_load && dtc_running),
        .i_in_data(fifo_in),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(fifo_out_valid),
        .o_out_data(fifo_out),
        .i_out_ready(fifo_pop)
    );

    // next state of sequencer and transfer unit
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.trigger_sync = {st_ff.trigger_sync[0], i_sample_trigger_input};
        nxt_st.trigger_prev = st_ff.trigger_sync[1];
        nxt_st.core_start = 1'b0;
        nxt_st.core_abort = 1'b0;
        nxt_st.wr.valid = 1'b0;
        if (!i_conversion_arm)
        begin
            nxt_st.rearm_needed = 1'b0;
        end
        if (result_load)
        begin
            nxt_st.result = i_core_data;
        end
        unique case (st_ff.state)
            SEQ_IDLE:
            begin
                if (i_conversion_arm && trigger_edge && !st_ff.rearm_needed)
                begin
                    nxt_st.channel = i_input_channel_select;
                    nxt_st.state = SEQ_START;
                end
            end
            SEQ_START:
            begin
                if (abort_now)
                begin
                    nxt_st.state = SEQ_IDLE;
                end
                else if (can_start)
                begin
                    nxt_st.core_start = 1'b1;
                    nxt_st.state = SEQ_CONVERT;
                end
            end
            SEQ_CONVERT:
            begin
                if (abort_now)
                begin
                    nxt_st.core_abort = 1'b1;
                    nxt_st.state = SEQ_IDLE;
                end
                else if (i_core_done)
                begin
                    unique case (i_conversion_sequence_select)
                        MODE_SINGLE:
                        begin
                            nxt_st.state = SEQ_IDLE;
                            nxt_st.rearm_needed = !i_trigger_is_software;
                        end
                        MODE_SEQUENCE:
                        begin
                            if (st_ff.channel == CHANNEL_ZERO)
                            begin
                                nxt_st.state = SEQ_IDLE;
                                nxt_st.rearm_needed = !i_trigger_is_software;
                            end
                            else
                            begin
                                nxt_st.channel = st_ff.channel - CHANNEL_STEP;
                                nxt_st.state = i_multi_sample_convert ? SEQ_START
                                    : SEQ_WAIT_TRIGGER;
                            end
                        end
                        MODE_REPEAT_SINGLE:
                        begin
                            if (!i_conversion_arm)
                            begin
                                nxt_st.state = SEQ_IDLE;
                            end
                            else
                            begin
                                nxt_st.state = i_multi_sample_convert ? SEQ_START
                                    : SEQ_WAIT_TRIGGER;
                            end
                        end
                        MODE_REPEAT_SEQUENCE:
                        begin
                            if (st_ff.channel != CHANNEL_ZERO)
                            begin
                                nxt_st.channel = st_ff.channel - CHANNEL_STEP;
                                nxt_st.state = i_multi_sample_convert ? SEQ_START
                                    : SEQ_WAIT_TRIGGER;
                            end
                            else if (!i_conversion_arm)
                            begin
                                nxt_st.state = SEQ_IDLE;
                            end
                            else
                            begin
                                nxt_st.channel = i_input_channel_select;
                                nxt_st.state = i_multi_sample_convert ? SEQ_START
                                    : SEQ_WAIT_TRIGGER;
                            end
                        end
                    endcase
                end
            end
            SEQ_WAIT_TRIGGER:
            begin
                // a sequence in flight ignores disarm until channel zero
                if (!i_conversion_arm && !is_sequence(i_conversion_sequence_select))
                begin
                    nxt_st.state = SEQ_IDLE;
                end
                else if (trigger_edge)
                begin
                    nxt_st.state = SEQ_START;
                end
            end
        endcase

        // a start address write rearms the transfer unit
        if (i_start_address_write)
        begin
            nxt_st.stopped = 1'b0;
            nxt_st.primed = 1'b0;
            nxt_st.in_block_two = 1'b0;
        end
        else if (fifo_pop)
        begin
            nxt_st.wr.valid = 1'b1;
            nxt_st.wr.address = cur_pointer;
            nxt_st.wr.data = WORD_WIDTH'(fifo_out.data);
            nxt_st.pointer = cur_pointer + POINTER_STEP;
            nxt_st.counter = cur_counter - COUNT_LAST;
            nxt_st.primed = 1'b1;
            if (cur_counter == COUNT_LAST)
            begin
                if (i_two_block_select && !st_ff.in_block_two)
                begin
                    // pointer runs on into the second block
                    nxt_st.block_one_full = 1'b1;
                    nxt_st.in_block_two = 1'b1;
                    nxt_st.counter = i_transfer_count;
                end
                else
                begin
                    nxt_st.in_block_two = 1'b0;
                    if (i_two_block_select)
                    begin
                        nxt_st.block_one_full = 1'b0;
                    end
                    if (i_continuous_transfer)
                    begin
                        nxt_st.pointer = i_transfer_start_address;
                        nxt_st.counter = i_transfer_count;
                    end
                    else
                    begin
                        nxt_st.stopped = 1'b1;
                    end
                end
            end
        end

        // flag: set wins over a clear in the same cycle
        nxt_st.completion = st_ff.completion && !i_completion_flag_clear;
        if ((result_load && !dtc_enabled)
            || (fifo_pop && !i_start_address_write && (cur_counter == COUNT_LAST)))
        begin
            nxt_st.completion = 1'b1;
        end
    end

    // register all state
    always_ff @(posedge i_clock)
    begin
        if (!i_resetn)
        begin
            st_ff <= '{state: SEQ_IDLE, channel: CHANNEL_ZERO, result: RESULT_RESET,
                       pointer: POINTER_RESET, counter: COUNT_ZERO, default: '0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // outputs
    assign o_core_start = st_ff.core_start;
    assign o_core_abort = st_ff.core_abort;
    assign o_core_channel = st_ff.channel;
    assign o_mem_write = st_ff.wr.valid;
    assign o_mem_address = st_ff.wr.address;
    assign o_mem_data = st_ff.wr.data;
    assign o_cpu_hold = st_ff.wr.valid;
    assign o_conversion_result = st_ff.result;
    assign o_converter_active = (st_ff.state != SEQ_IDLE);
    assign o_completion_flag = st_ff.completion;
    assign o_block_one_full = st_ff.block_one_full;

    // checks
    sequence s_load;
        result_load && !abort_now;
    endsequence

    sequence s_restart;
        st_ff.state == SEQ_START;
    endsequence

    start_channel_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        st_ff.state == SEQ_IDLE && nxt_st.state == SEQ_START
        |=> st_ff.channel == $past(i_input_channel_select))
        else $error("start channel not taken from select");

    seq_descend_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        s_load and (is_sequence(i_conversion_sequence_select)
        && st_ff.channel != CHANNEL_ZERO)
        |=> st_ff.channel == $past(st_ff.channel) - CHANNEL_STEP)
        else $error("sequence channel did not step down");

    seq_stop_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        s_load and (i_conversion_sequence_select == MODE_SEQUENCE
        && st_ff.channel == CHANNEL_ZERO)
        |=> st_ff.state == SEQ_IDLE && !o_converter_active)
        else $error("sequence did not stop after channel zero");

    result_store_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        result_load |=> o_conversion_result == $past(i_core_data))
        else $error("result not stored");

    msc_auto_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        s_load and (i_multi_sample_convert && i_conversion_arm
        && i_conversion_sequence_select == MODE_REPEAT_SINGLE) |=> s_restart)
        else $error("automatic restart missing");

    abort_halt_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        st_ff.state == SEQ_CONVERT && !i_conversion_arm
        && i_conversion_sequence_select == MODE_SINGLE
        |=> o_core_abort && st_ff.state == SEQ_IDLE)
        else $error("immediate halt missing");

    xfer_cycle_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        fifo_pop && !i_start_address_write |=> o_mem_write && o_cpu_hold
        && o_mem_address == $past(cur_pointer))
        else $error("transfer cycle wrong");

    ptr_step_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        fifo_pop && !i_start_address_write && cur_counter > COUNT_LAST
        |=> st_ff.pointer == $past(cur_pointer) + POINTER_STEP
        && st_ff.counter == $past(cur_counter) - COUNT_LAST)
        else $error("pointer or counter step wrong");

    flag_direct_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        result_load && !dtc_enabled |=> o_completion_flag)
        else $error("flag not set on result load");

    rearm_block_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        st_ff.state == SEQ_IDLE && st_ff.rearm_needed |=> st_ff.state == SEQ_IDLE)
        else $error("started without rearm");

endmodule // conv_seq

// ==== rtl/conv_seq_pkg.sv ====
// Purpose: shared constants and carrier types for the converter sequencer
// Assumes: 10-bit results, 16-bit memory addresses, byte-wide transfer count
// Notes: mode codes follow the two-bit sequence select field
package conv_seq_pkg;

    // widths
    localparam int RESULT_WIDTH = 10;
    localparam int CHANNEL_WIDTH = 4;
    localparam int ADDRESS_WIDTH = 16;
    localparam int COUNT_WIDTH = 8;
    localparam int WORD_WIDTH = 16;
    localparam int FIFO_DEPTH = 32;

    // conversion sequence select codes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_SEQUENCE = 2'h1;
    localparam logic [1:0] MODE_REPEAT_SINGLE = 2'h2;
    localparam logic [1:0] MODE_REPEAT_SEQUENCE = 2'h3;

    // transfer unit and channel arithmetic, reset values
    localparam logic [ADDRESS_WIDTH-1:0] POINTER_STEP = 16'h0002;
    localparam logic [ADDRESS_WIDTH-1:0] POINTER_RESET = 16'h0000;
    localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = 8'h00;
    localparam logic [COUNT_WIDTH-1:0] COUNT_LAST = 8'h01;
    localparam logic [CHANNEL_WIDTH-1:0] CHANNEL_ZERO = 4'h0;
    localparam logic [CHANNEL_WIDTH-1:0] CHANNEL_STEP = 4'h1;
    localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 10'h000;

    // sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_START,
        SEQ_CONVERT,
        SEQ_WAIT_TRIGGER
    } seq_state_type;

    // one result word queued for transfer
    typedef struct packed {
        logic [RESULT_WIDTH-1:0] data;
    } result_word_type;

    // one memory write cycle on the system bus
    typedef struct packed {
        logic valid;
        logic [ADDRESS_WIDTH-1:0] address;
        logic [WORD_WIDTH-1:0] data;
    } mem_write_type;

endpackage
